//--- rtl/block_range_decode.sv
// erase block select to address range decoder
`timescale 1ns/1ps
module block_range_decode
#(
  parameter int BLOCKS = 5
)
(
  // one-hot block select
  input wire logic [BLOCKS-1:0] sel,
  // decoded range
  output flash_ctl_pkg::erase_range_t range
);

  logic [14:0] small_first;

  // small block base from lowest set bit
  always_comb
  begin
    small_first = '0;
    for (int i = BLOCKS - 2; i >= 0; i--)
    begin
      if (sel[i])
      begin
        small_first = 15'(flash_ctl_pkg::SMALL_SIZE * i);
      end
    end
  end

  // range select; large block wins if set
  always_comb
  begin
    range.valid = |sel;
    if (sel[flash_ctl_pkg::BIT_LARGE])
    begin
      range.first = flash_ctl_pkg::LARGE_BASE;
      range.last = flash_ctl_pkg::LARGE_LAST;
    end
    else
    begin
      range.first = small_first;
      range.last = small_first + flash_ctl_pkg::SMALL_SIZE - 15'h0001;
    end
  end

endmodule

//--- rtl/flash_ctl_pkg.sv
// shared constants and types for the flash program/erase control block
package flash_ctl_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_BLOCK = 8'h08;
  localparam logic [7:0] OFS_POWER = 8'h0c;
  localparam logic [7:0] OFS_ACCESS = 8'h10;
  localparam logic [7:0] OFS_FAULT_CAUSE = 8'h14;

  // control register field positions
  localparam int BIT_PROG = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_WCHECK = 2;
  localparam int BIT_ECHECK = 3;
  localparam int BIT_WSETUP = 4;
  localparam int BIT_ESETUP = 5;
  localparam int BIT_PERMIT = 6;
  localparam int BIT_TOP = 7;

  // block select field
  localparam int BLOCK_BITS = 5;
  localparam int BIT_LARGE = 4;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [BLOCK_BITS-1:0] RST_BLOCK = 5'h00;

  // array geometry
  localparam logic [14:0] SMALL_SIZE = 15'h0400;
  localparam logic [14:0] LARGE_BASE = 15'h1000;
  localparam logic [14:0] LARGE_LAST = 15'h7fff;
  localparam logic [14:0] UNIT_MASK = 15'h007f;

  // fault cause codes
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_SEQ = 2'h1;
  localparam logic [1:0] CAUSE_ARRAY = 2'h2;

  // array operating state
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_WSETUP = 3'b001,
    ST_PROGRAM = 3'b010,
    ST_WCHECK = 3'b011,
    ST_ESETUP = 3'b100,
    ST_ERASE = 3'b101,
    ST_ECHECK = 3'b110,
    ST_PROTECT = 3'b111
  } array_state_t;

  // erase target range handed to the array
  typedef struct packed
  {
    logic valid;
    logic [14:0] first;
    logic [14:0] last;
  } erase_range_t;

endpackage

//--- rtl/flash_program_erase_control.sv
// flash program/erase control registers and array sequencing state
//
// Functional notes
// - write_permit enables program/erase; when clear, other bits cannot be set
// - erase_setup bit enters erase setup state; clearing cancels it
// - write_setup bit enters program setup state; clearing cancels it
// - erase_check bit enters erase-verify mode; clearing leaves it
// - write_check bit enters program-verify mode; clearing leaves it
// - erase mode only with erase, write_permit and erase_setup all set
// - program mode only with program, write_permit and write_setup set
// - reserved bits of all six registers read as zero
// - operation_fault set on program/erase error; forces protection
// - block select forced to zero while write_permit is clear
// - more than one block select bit set clears the whole register
// - block_sel_large selects 1000 to 7fff for erase
// - block_sel_0..3 each select one 1-kbyte block from 0000 to 0fff
// - powerdown_inhibit clear lets subactive entry power down the array
// - power-down only partly halts supply; array stays readable
// - ctrl_reg_gate set permits access to the four control registers
// - all defined bits reset to zero
// - program in 128-byte aligned units; erase one block at a time
`timescale 1ns/1ps
module flash_program_erase_control
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // array side events and status
  input wire logic array_error,
  input wire logic subactive_mode,
  input wire logic [14:0] program_addr,
  // array controls
  output flash_ctl_pkg::array_state_t array_state,
  output flash_ctl_pkg::erase_range_t erase_range,
  output logic array_powerdown,
  output logic array_readable
);

  ////////////////////////////////////////////////////////////////////
  // register state

  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic fault_q;
  logic fault_d;
  logic [1:0] cause_q;
  logic [1:0] cause_d;
  logic [flash_ctl_pkg::BLOCK_BITS-1:0] block_q;
  logic [flash_ctl_pkg::BLOCK_BITS-1:0] block_d;
  logic inhibit_q;
  logic gate_q;
  logic [31:0] rdata_d;
  flash_ctl_pkg::array_state_t state_d;
  flash_ctl_pkg::array_state_t state_q;

  ////////////////////////////////////////////////////////////////////
  // bus decode

  wire access_w = psel && penable && pwrite;
  wire setup_rd = psel && !penable && !pwrite;
  wire hit_ctrl = paddr == flash_ctl_pkg::OFS_CONTROL;
  wire hit_stat = paddr == flash_ctl_pkg::OFS_STATUS;
  wire hit_block = paddr == flash_ctl_pkg::OFS_BLOCK;
  wire hit_power = paddr == flash_ctl_pkg::OFS_POWER;
  wire hit_access = paddr == flash_ctl_pkg::OFS_ACCESS;
  wire hit_cause = paddr == flash_ctl_pkg::OFS_FAULT_CAUSE;
  wire hit_any = hit_ctrl || hit_stat || hit_block || hit_power ||
    hit_access || hit_cause;
  wire gated = gate_q;
  wire wr_ctrl = access_w && hit_ctrl && gated;
  wire wr_block = access_w && hit_block && gated;
  wire wr_power = access_w && hit_power && gated;
  wire wr_access = access_w && hit_access;
  wire [7:0] wbyte = pwdata[7:0];

  // zero-wait slave; unmapped address flags an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  ////////////////////////////////////////////////////////////////////
  // control register next value

  wire permit_next = wr_ctrl ? wbyte[flash_ctl_pkg::BIT_PERMIT] :
    ctrl_q[flash_ctl_pkg::BIT_PERMIT];

  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
    begin
      ctrl_d = wbyte;
      ctrl_d[flash_ctl_pkg::BIT_TOP] = 1'b0;
      if (!wbyte[flash_ctl_pkg::BIT_PERMIT])
      begin
        ctrl_d = flash_ctl_pkg::RST_BYTE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // block select next value

  always_comb
  begin
    block_d = block_q;
    if (wr_block)
    begin
      block_d = wbyte[flash_ctl_pkg::BLOCK_BITS-1:0];
      if ($countones(block_d) > 1)
      begin
        block_d = flash_ctl_pkg::RST_BLOCK;
      end
    end
    if (!permit_next)
    begin
      block_d = flash_ctl_pkg::RST_BLOCK;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // fault flag; hardware set only, no software clear

  wire prog_active = state_q == flash_ctl_pkg::ST_PROGRAM;
  wire erase_active = state_q == flash_ctl_pkg::ST_ERASE;
  wire unit_ok;
  wire bad_erase = erase_active && !erase_range.valid;
  wire bad_prog = prog_active && !unit_ok;

  always_comb
  begin
    fault_d = fault_q;
    cause_d = cause_q;
    if (!fault_q && (prog_active || erase_active))
    begin
      if (array_error)
      begin
        fault_d = 1'b1;
        cause_d = flash_ctl_pkg::CAUSE_ARRAY;
      end
      else if (bad_erase || bad_prog)
      begin
        fault_d = 1'b1;
        cause_d = flash_ctl_pkg::CAUSE_SEQ;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // array state from control bits

  wire [7:0] c = ctrl_q;

  always_comb
  begin
    state_d = flash_ctl_pkg::ST_IDLE;
    if (fault_q)
    begin
      state_d = flash_ctl_pkg::ST_PROTECT;
    end
    else if (c[flash_ctl_pkg::BIT_PERMIT])
    begin
      if (c[flash_ctl_pkg::BIT_PROG] && c[flash_ctl_pkg::BIT_WSETUP])
      begin
        state_d = flash_ctl_pkg::ST_PROGRAM;
      end
      else if (c[flash_ctl_pkg::BIT_ERASE] && c[flash_ctl_pkg::BIT_ESETUP])
      begin
        state_d = flash_ctl_pkg::ST_ERASE;
      end
      else if (c[flash_ctl_pkg::BIT_WCHECK])
      begin
        state_d = flash_ctl_pkg::ST_WCHECK;
      end
      else if (c[flash_ctl_pkg::BIT_ECHECK])
      begin
        state_d = flash_ctl_pkg::ST_ECHECK;
      end
      else if (c[flash_ctl_pkg::BIT_WSETUP])
      begin
        state_d = flash_ctl_pkg::ST_WSETUP;
      end
      else if (c[flash_ctl_pkg::BIT_ESETUP])
      begin
        state_d = flash_ctl_pkg::ST_ESETUP;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read mux

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (hit_access)
    begin
      rdata_d[flash_ctl_pkg::BIT_TOP] = gate_q;
    end
    else if (hit_cause)
    begin
      rdata_d[1:0] = cause_q;
    end
    else if (gated)
    begin
      case (1'b1)
        hit_ctrl: rdata_d[7:0] = ctrl_q;
        hit_stat: rdata_d[flash_ctl_pkg::BIT_TOP] = fault_q;
        hit_block: rdata_d[flash_ctl_pkg::BLOCK_BITS-1:0] = block_q;
        hit_power: rdata_d[flash_ctl_pkg::BIT_TOP] = inhibit_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers

  // control, block, fault
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_q <= flash_ctl_pkg::RST_BYTE;
      block_q <= flash_ctl_pkg::RST_BLOCK;
      fault_q <= 1'b0;
      cause_q <= flash_ctl_pkg::CAUSE_NONE;
      state_q <= flash_ctl_pkg::ST_IDLE;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      block_q <= block_d;
      fault_q <= fault_d;
      cause_q <= cause_d;
      state_q <= state_d;
    end
  end

  // power and access registers
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      inhibit_q <= 1'b0;
      gate_q <= 1'b0;
    end
    else
    begin
      if (wr_power)
      begin
        inhibit_q <= wbyte[flash_ctl_pkg::BIT_TOP];
      end
      if (wr_access)
      begin
        gate_q <= wbyte[flash_ctl_pkg::BIT_TOP];
      end
    end
  end

  // read data captured in setup phase
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (setup_rd)
    begin
      prdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign array_state = state_q;
  assign array_powerdown = subactive_mode && !inhibit_q;
  assign array_readable = 1'b1;

  block_range_decode #(.BLOCKS(flash_ctl_pkg::BLOCK_BITS)) u_range
  (
    .sel(block_q),
    .range(erase_range)
  );

  program_unit_check u_unit
  (
    .addr(program_addr),
    .aligned(unit_ok)
  );

  ////////////////////////////////////////////////////////////////////
  // assertions

  AST_BLOCK_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !ctrl_q[flash_ctl_pkg::BIT_PERMIT] |-> block_q == '0)
    else $error("block select nonzero without write permit");

  AST_ONE_HOT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $countones(block_q) <= 1)
    else $error("more than one erase block selected");

  AST_PERMIT_GATE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !ctrl_q[flash_ctl_pkg::BIT_PERMIT] |-> ctrl_q == 8'h00)
    else $error("control bits set without write permit");

  AST_PROG_ENTRY: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == flash_ctl_pkg::ST_PROGRAM) |->
    $past(ctrl_q[flash_ctl_pkg::BIT_WSETUP]) &&
    $past(ctrl_q[flash_ctl_pkg::BIT_PROG]))
    else $error("program mode without setup and program bits");

  AST_ERASE_ENTRY: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == flash_ctl_pkg::ST_ERASE) |->
    $past(ctrl_q[flash_ctl_pkg::BIT_ESETUP]) &&
    $past(ctrl_q[flash_ctl_pkg::BIT_ERASE]))
    else $error("erase mode without setup and erase bits");

  AST_PROTECT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fault_q |=> state_q == flash_ctl_pkg::ST_PROTECT)
    else $error("fault without protection state");

  AST_FAULT_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ((prog_active || erase_active) && array_error && !fault_q)
    |=> fault_q)
    else $error("array error did not set fault flag");

  AST_GATED_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (access_w && hit_ctrl && !gate_q) |=> $stable(ctrl_q))
    else $error("control register changed while gated");

  AST_POWERDOWN: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_power && wbyte[flash_ctl_pkg::BIT_TOP]) |=> !array_powerdown)
    else $error("power-down not inhibited after inhibit write");

  AST_RESERVED: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (psel && penable && !pwrite && (hit_stat || hit_power || hit_access))
    |-> prdata[6:0] == 7'h00)
    else $error("reserved bits read nonzero");

endmodule

//--- rtl/program_unit_check.sv
// check that a program address starts a 128-byte unit
`timescale 1ns/1ps
module program_unit_check
(
  // start address
  input wire logic [14:0] addr,
  // aligned flag
  output logic aligned
);

  // lower seven bits zero means unit start at 00 or 80
  assign aligned = (addr & flash_ctl_pkg::UNIT_MASK) == 15'h0000;

endmodule

//--- sim/flash_program_erase_control_test.sv
// self-checking bench for the flash program/erase control block
`timescale 1ns/1ps
module flash_program_erase_control_test;
  ////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic array_error = 1'b0;
  logic subactive_mode = 1'b0;
  logic [14:0] program_addr = 15'h0000;
  flash_ctl_pkg::array_state_t array_state;
  flash_ctl_pkg::erase_range_t erase_range;
  logic array_powerdown;
  logic array_readable;
  int err_total = 0;
  int checks_done = 0;
  int seed = 20;
  logic [32:0] expq[$];
  logic [32:0] e;

  flash_program_erase_control uut
  (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .array_error(array_error),
    .subactive_mode(subactive_mode), .program_addr(program_addr),
    .array_state(array_state), .erase_range(erase_range),
    .array_powerdown(array_powerdown), .array_readable(array_readable)
  );

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////
  // comparison and closing
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // apb master: setup, access until pready, then release
  task automatic apb(input logic is_wr, input logic [7:0] a,
    input logic [31:0] d, input logic [32:0] exp);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    expq.push_back(exp);
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    // only the watchdog ends a wait for pready
    while (pready !== 1'b1)
    begin
      @(posedge sys_clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    apb(1'b0, a, 32'h0, {1'b0, 24'h0, d});
  endtask

  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
  endtask

  // state check two edges after the register update
  task automatic st(input flash_ctl_pkg::array_state_t s);
    repeat (2) @(posedge sys_clk);
    chk("array_state", {29'h0, array_state}, {29'h0, s});
  endtask

  // expected erase range of one select bit
  function automatic logic [31:0] rng(input int i);
    logic [14:0] f;
    logic [14:0] l;
    f = (i == 4) ? 15'h1000 : 15'(i * 1024);
    l = (i == 4) ? 15'h7fff : f + 15'h03ff;
    return {1'b0, 1'b1, f, l};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // monitor: oldest note against each completed transfer
  always @(posedge sys_clk)
  begin
    if (psel && penable && pready === 1'b1 && expq.size() > 0)
    begin
      e = expq.pop_front();
      chk("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
      if (!pwrite)
        chk("prdata", prdata, e[31:0]);
    end
  end

  // watchdog
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////
  // main sequence
  flash_ctl_pkg::array_state_t sexp[8];
  logic [7:0] cval[8];
  initial
  begin
    sexp = '{flash_ctl_pkg::ST_WSETUP, flash_ctl_pkg::ST_PROGRAM,
      flash_ctl_pkg::ST_IDLE, flash_ctl_pkg::ST_WCHECK,
      flash_ctl_pkg::ST_ECHECK, flash_ctl_pkg::ST_ESETUP,
      flash_ctl_pkg::ST_ERASE, flash_ctl_pkg::ST_ERASE};
    // setup bits lead program and erase bits, except 41, which sets program with write_setup clear
    cval = '{8'h50, 8'h51, 8'h41, 8'h44, 8'h48, 8'h60, 8'h62, 8'he2};
    do_reset();
    rd(flash_ctl_pkg::OFS_ACCESS, 8'h00);
    wr(flash_ctl_pkg::OFS_CONTROL, 8'h40);
    wr(flash_ctl_pkg::OFS_ACCESS, 8'hff);
    rd(flash_ctl_pkg::OFS_ACCESS, 8'h80);
    rd(flash_ctl_pkg::OFS_CONTROL, 8'h00);
    rd(flash_ctl_pkg::OFS_STATUS, 8'h00);
    rd(flash_ctl_pkg::OFS_BLOCK, 8'h00);
    rd(flash_ctl_pkg::OFS_POWER, 8'h00);
    wr(flash_ctl_pkg::OFS_CONTROL, 8'h3f);
    rd(flash_ctl_pkg::OFS_CONTROL, 8'h00);
    wr(flash_ctl_pkg::OFS_BLOCK, 8'h01);
    rd(flash_ctl_pkg::OFS_BLOCK, 8'h00);
    wr(flash_ctl_pkg::OFS_CONTROL, 8'h40);
    wr(flash_ctl_pkg::OFS_BLOCK, 8'h03);
    rd(flash_ctl_pkg::OFS_BLOCK, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      wr(flash_ctl_pkg::OFS_BLOCK, 8'h01 << i);
      rd(flash_ctl_pkg::OFS_BLOCK, 8'h01 << i);
      chk("erase_range", {1'b0, erase_range}, rng(i));
    end
    program_addr <= 15'($random(seed)) & 15'h7f80;
    for (int i = 0; i < 8; i++)
    begin
      wr(flash_ctl_pkg::OFS_CONTROL, cval[i]);
      st(sexp[i]);
    end
    rd(flash_ctl_pkg::OFS_CONTROL, 8'h62);
    wr(flash_ctl_pkg::OFS_CONTROL, 8'h40);
    st(flash_ctl_pkg::ST_IDLE);
    wr(flash_ctl_pkg::OFS_CONTROL, 8'h00);
    rd(flash_ctl_pkg::OFS_BLOCK, 8'h00);
    // status is never written; the cause register ignores a write
    wr(flash_ctl_pkg::OFS_FAULT_CAUSE, 8'h03);
    rd(flash_ctl_pkg::OFS_FAULT_CAUSE, 8'h00);
    rd(flash_ctl_pkg::OFS_STATUS, 8'h00);
    wr(flash_ctl_pkg::OFS_CONTROL, 8'h40);
    wr(flash_ctl_pkg::OFS_ACCESS, 8'h00);
    rd(flash_ctl_pkg::OFS_CONTROL, 8'h00);
    wr(flash_ctl_pkg::OFS_ACCESS, 8'h80);
    rd(flash_ctl_pkg::OFS_CONTROL, 8'h40);
    wr(flash_ctl_pkg::OFS_POWER, 8'hff);
    rd(flash_ctl_pkg::OFS_POWER, 8'h80);
    subactive_mode <= 1'b1;
    st(flash_ctl_pkg::ST_IDLE);
    chk("powerdown", {31'h0, array_powerdown}, 32'h0);
    wr(flash_ctl_pkg::OFS_POWER, 8'h00);
    st(flash_ctl_pkg::ST_IDLE);
    chk("powerdown", {31'h0, array_powerdown}, 32'h1);
    chk("readable", {31'h0, array_readable}, 32'h1);
    subactive_mode <= 1'b0;
    apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0});
    // misaligned program start raises the fault
    wr(flash_ctl_pkg::OFS_CONTROL, 8'h50);
    program_addr <= (15'($random(seed)) & 15'h7f80) | 15'h0001;
    wr(flash_ctl_pkg::OFS_CONTROL, 8'h51);
    // fault lands one edge after program mode, protection one later
    repeat (2) @(posedge sys_clk);
    st(flash_ctl_pkg::ST_PROTECT);
    rd(flash_ctl_pkg::OFS_STATUS, 8'h80);
    rd(flash_ctl_pkg::OFS_FAULT_CAUSE, {6'h00, flash_ctl_pkg::CAUSE_SEQ});
    // second reset, then an array error during erase
    do_reset();
    wr(flash_ctl_pkg::OFS_ACCESS, 8'h80);
    rd(flash_ctl_pkg::OFS_STATUS, 8'h00);
    wr(flash_ctl_pkg::OFS_CONTROL, 8'h40);
    wr(flash_ctl_pkg::OFS_BLOCK, 8'h02);
    wr(flash_ctl_pkg::OFS_CONTROL, 8'h60);
    wr(flash_ctl_pkg::OFS_CONTROL, 8'h62);
    st(flash_ctl_pkg::ST_ERASE);
    array_error <= 1'b1;
    @(posedge sys_clk);
    array_error <= 1'b0;
    st(flash_ctl_pkg::ST_PROTECT);
    rd(flash_ctl_pkg::OFS_STATUS, 8'h80);
    rd(flash_ctl_pkg::OFS_FAULT_CAUSE, {6'h00, flash_ctl_pkg::CAUSE_ARRAY});
    repeat (3) @(posedge sys_clk);
    chk("queue", 32'(expq.size()), 32'h0);
    final_report();
  end
endmodule
